// ---- csr_regs.sv ----
/*
 Status, result and capacitive setup registers of the converter.
 Link side runs on link_clk_in and carries byte commands from the serial
 front end (pointer write, data write, data read, stop); core side runs on
 clk_in and takes conversion results from the converter.
 Assumes a command is offered only while link_busy_out is low.
*/
`timescale 1ns/1ps
`default_nettype none
`include "csr_map.svh"

module csr_regs
(
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic link_clk_in,
   input wire logic link_cmd_valid_in,
   input wire csr_pkg::csr_cmd_t link_cmd_in,
   output logic link_busy_out,
   output logic [7:0] link_rdata_out,
   output logic link_rvalid_out,
   input wire logic cap_done_in,
   input wire logic [23:0] cap_result_in,
   input wire logic vt_done_in,
   input wire logic [23:0] vt_result_in,
   input wire logic vt_channel_on_in,
   input wire logic conv_start_in,
   input wire logic excitation_fault_in,
   output csr_pkg::csr_cap_setup_t cap_setup_out,
   output logic ready_n_out
);

   // link domain
   csr_pkg::csr_link_state_t lst_q;
   csr_pkg::csr_cmd_t hold_q;
   logic req_tgl_q;
   logic [2:0] ack_sync_q;
   logic ack_seen_q;
   logic [7:0] link_rdata_q;
   logic link_rvalid_q;
   logic ack_tgl_q;
   logic [7:0] rdata_q;
   wire logic ack_evt;
   wire logic cmd_take;

   assign cmd_take = link_cmd_valid_in && (lst_q == csr_pkg::CSR_LS_IDLE);
   assign ack_evt = (ack_sync_q[1] == ack_sync_q[2]) &&
                    (ack_sync_q[2] != ack_seen_q);

   always_ff @(posedge link_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         lst_q <= csr_pkg::CSR_LS_IDLE;
         hold_q <= '0;
         req_tgl_q <= 1'b0;
      end
      else if (cmd_take)
      begin
         lst_q <= csr_pkg::CSR_LS_WAIT;
         hold_q <= link_cmd_in;
         req_tgl_q <= ~req_tgl_q;
      end
      else if (ack_evt)
      begin
         lst_q <= csr_pkg::CSR_LS_IDLE;
      end
   end

   always_ff @(posedge link_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         ack_sync_q <= 3'h0;
         ack_seen_q <= 1'b0;
      end
      else
      begin
         ack_sync_q <= {ack_sync_q[1:0], ack_tgl_q};
         if (ack_evt)
         begin
            ack_seen_q <= ack_sync_q[2];
         end
      end
   end

   always_ff @(posedge link_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         link_rdata_q <= `CSR_RST_BYTE;
         link_rvalid_q <= 1'b0;
      end
      else
      begin
         link_rvalid_q <= ack_evt && (hold_q.kind == csr_pkg::CSR_CMD_RD);
         if (ack_evt && (hold_q.kind == csr_pkg::CSR_CMD_RD))
         begin
            link_rdata_q <= rdata_q;
         end
      end
   end

   assign link_busy_out = (lst_q == csr_pkg::CSR_LS_WAIT);
   assign link_rdata_out = link_rdata_q;
   assign link_rvalid_out = link_rvalid_q;

   // core domain: request toggle crossing, command word held stable
   logic [2:0] req_sync_q;
   logic req_seen_q;
   wire logic req_evt;

   assign req_evt = (req_sync_q[1] == req_sync_q[2]) &&
                    (req_sync_q[2] != req_seen_q);

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         req_sync_q <= 3'h0;
         req_seen_q <= 1'b0;
         ack_tgl_q <= 1'b0;
      end
      else
      begin
         req_sync_q <= {req_sync_q[1:0], req_tgl_q};
         if (req_evt)
         begin
            req_seen_q <= req_sync_q[2];
            ack_tgl_q <= ~ack_tgl_q;
         end
      end
   end

   wire logic is_ptr;
   wire logic is_wr;
   wire logic is_rd;
   wire logic is_stop;
   assign is_ptr = req_evt && (hold_q.kind == csr_pkg::CSR_CMD_PTR);
   assign is_wr = req_evt && (hold_q.kind == csr_pkg::CSR_CMD_WR);
   assign is_rd = req_evt && (hold_q.kind == csr_pkg::CSR_CMD_RD);
   assign is_stop = req_evt && (hold_q.kind == csr_pkg::CSR_CMD_STOP);

   // address pointer
   logic [7:0] ptr_q;

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         ptr_q <= `CSR_PTR_STATUS;
      end
      else if (is_ptr)
      begin
         ptr_q <= hold_q.data;
      end
      else if (is_wr || is_rd)
      begin
         ptr_q <= ptr_q + 8'h01;
      end
   end

   function automatic logic in_range(input logic [7:0] p,
                                     input logic [7:0] lo,
                                     input logic [7:0] hi);
      in_range = (p >= lo) && (p <= hi);
   endfunction

   // excitation fault pin: three flops, change taken once stages 2 and 3 agree
   logic [2:0] exc_sync_q;
   logic exc_q;

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         exc_sync_q <= 3'h0;
         exc_q <= 1'b0;
      end
      else
      begin
         exc_sync_q <= {exc_sync_q[1:0], excitation_fault_in};
         if (exc_sync_q[1] == exc_sync_q[2])
         begin
            exc_q <= exc_sync_q[2];
         end
      end
   end

   // capacitive setup
   logic [7:0] setup_q;
   wire logic setup_wr;
   wire logic [7:0] setup_mask;

   assign setup_wr = is_wr && (ptr_q == `CSR_PTR_CAP_SETUP);
   assign setup_mask = (8'h01 << `CSR_SU_ON_BIT) |
                       (8'h01 << `CSR_SU_IN2_BIT) |
                       (8'h01 << `CSR_SU_DIFF_BIT) |
                       (8'h01 << `CSR_SU_CHOP_BIT);

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         setup_q <= `CSR_RST_BYTE;
      end
      else if (setup_wr)
      begin
         setup_q <= hold_q.data & setup_mask;
      end
   end

   assign cap_setup_out.channel_on = setup_q[`CSR_SU_ON_BIT];
   assign cap_setup_out.second_input_select =
      setup_q[`CSR_SU_IN2_BIT];
   assign cap_setup_out.differential_select =
      setup_q[`CSR_SU_DIFF_BIT];
   assign cap_setup_out.capacitive_chopping =
      setup_q[`CSR_SU_CHOP_BIT];

   // result read-in-progress tracking, ended only by stop
   logic cap_busy_q;
   logic vt_busy_q;
   wire logic cap_byte_rd;
   wire logic vt_byte_rd;

   assign cap_byte_rd = is_rd &&
      in_range(ptr_q, `CSR_PTR_CAP_H, `CSR_PTR_CAP_L);
   assign vt_byte_rd = is_rd &&
      in_range(ptr_q, `CSR_PTR_VT_H, `CSR_PTR_VT_L);

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         cap_busy_q <= 1'b0;
         vt_busy_q <= 1'b0;
      end
      else if (is_stop)
      begin
         cap_busy_q <= 1'b0;
         vt_busy_q <= 1'b0;
      end
      else
      begin
         cap_busy_q <= cap_busy_q || cap_byte_rd;
         vt_busy_q <= vt_busy_q || vt_byte_rd;
      end
   end

   // result registers; converter codes kept as offset binary
   logic [23:0] cap_res_q;
   logic [23:0] vt_res_q;
   wire logic cap_load;
   wire logic vt_load;

   assign cap_load = cap_done_in && !cap_busy_q && !cap_byte_rd;
   assign vt_load = vt_done_in && !vt_busy_q && !vt_byte_rd;

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         cap_res_q <= `CSR_RST_RESULT;
         vt_res_q <= `CSR_RST_RESULT;
      end
      else
      begin
         if (cap_load)
         begin
            cap_res_q <= cap_result_in;
         end
         if (vt_load)
         begin
            vt_res_q <= vt_result_in;
         end
      end
   end

   // done flags, active low; a completing read clears its flag and a result arriving with it is not loaded
   logic cap_done_n_q;
   logic vt_done_n_q;
   logic rdy_block_q;
   logic rdy_n_q;
   wire logic cap_read_end;
   wire logic vt_read_end;
   wire logic cap_ok;
   wire logic vt_ok;
   wire logic any_on;
   wire logic rdy_n_d;

   assign cap_read_end = is_rd && (ptr_q == `CSR_PTR_CAP_L);
   assign vt_read_end = is_rd && (ptr_q == `CSR_PTR_VT_L);

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         cap_done_n_q <= 1'b1;
         vt_done_n_q <= 1'b1;
      end
      else
      begin
         if (cap_load)
         begin
            cap_done_n_q <= 1'b0;
         end
         else if (cap_read_end)
         begin
            cap_done_n_q <= 1'b1;
         end
         if (vt_load)
         begin
            vt_done_n_q <= 1'b0;
         end
         else if (vt_read_end)
         begin
            vt_done_n_q <= 1'b1;
         end
      end
   end

   // combined flag: held high from a conversion start until a result lands
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         rdy_block_q <= 1'b0;
      end
      else if (conv_start_in)
      begin
         rdy_block_q <= 1'b1;
      end
      else if (cap_load || vt_load)
      begin
         rdy_block_q <= 1'b0;
      end
   end

   assign any_on = setup_q[`CSR_SU_ON_BIT] || vt_channel_on_in;
   assign cap_ok = !setup_q[`CSR_SU_ON_BIT] || !cap_done_n_q;
   assign vt_ok = !vt_channel_on_in || !vt_done_n_q;
   assign rdy_n_d = rdy_block_q ||
                    !(any_on && cap_ok && vt_ok);

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         rdy_n_q <= 1'b1;
      end
      else
      begin
         rdy_n_q <= rdy_n_d;
      end
   end

   assign ready_n_out = rdy_n_q;

   // read data mux
   wire logic [7:0] status_byte;
   logic [7:0] rd_mux;

   assign status_byte = {4'h0, exc_q, rdy_n_q, vt_done_n_q,
                         cap_done_n_q};

   always_comb
   begin
      case (ptr_q)
         `CSR_PTR_STATUS: rd_mux = status_byte;
         `CSR_PTR_CAP_H: rd_mux = cap_res_q[23:16];
         `CSR_PTR_CAP_M: rd_mux = cap_res_q[15:8];
         `CSR_PTR_CAP_L: rd_mux = cap_res_q[7:0];
         `CSR_PTR_VT_H: rd_mux = vt_res_q[23:16];
         `CSR_PTR_VT_M: rd_mux = vt_res_q[15:8];
         `CSR_PTR_VT_L: rd_mux = vt_res_q[7:0];
         `CSR_PTR_CAP_SETUP: rd_mux = setup_q;
         default: rd_mux = `CSR_RST_BYTE;
      endcase
   end

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         rdata_q <= `CSR_RST_BYTE;
      end
      else if (is_rd)
      begin
         rdata_q <= rd_mux;
      end
   end

endmodule

`default_nettype wire

// ---- csr_map.svh ----
/*
 Register map, field positions, reset values and command codes of the
 converter status, result and capacitive setup register group.
 Assumes it is included by its bare name in the package and the design.
*/
`ifndef CSR_MAP_SVH
`define CSR_MAP_SVH

`define CSR_PTR_STATUS 8'h00
`define CSR_PTR_CAP_H 8'h01
`define CSR_PTR_CAP_M 8'h02
`define CSR_PTR_CAP_L 8'h03
`define CSR_PTR_VT_H 8'h04
`define CSR_PTR_VT_M 8'h05
`define CSR_PTR_VT_L 8'h06
`define CSR_PTR_CAP_SETUP 8'h07

`define CSR_ST_EXC_BIT 3
`define CSR_ST_RDY_BIT 2
`define CSR_ST_VT_BIT 1
`define CSR_ST_CAP_BIT 0

`define CSR_SU_ON_BIT 7
`define CSR_SU_IN2_BIT 6
`define CSR_SU_DIFF_BIT 5
`define CSR_SU_CHOP_BIT 0

`define CSR_RST_RESULT 24'h000000
`define CSR_RST_BYTE 8'h00

`define CSR_CMD_PTR 2'h0
`define CSR_CMD_WR 2'h1
`define CSR_CMD_RD 2'h2
`define CSR_CMD_STOP 2'h3

`endif

// ---- csr_pkg.sv ----
/*
 Types shared by the register group: link command word and setup fields.
 Assumes csr_map.svh is on the include path.
*/
`default_nettype none
`include "csr_map.svh"

package csr_pkg;

   typedef enum logic [1:0]
   {
      CSR_CMD_PTR = `CSR_CMD_PTR,
      CSR_CMD_WR = `CSR_CMD_WR,
      CSR_CMD_RD = `CSR_CMD_RD,
      CSR_CMD_STOP = `CSR_CMD_STOP
   } csr_cmd_kind_t;

   typedef struct packed
   {
      csr_cmd_kind_t kind;
      logic [7:0] data;
   } csr_cmd_t;

   typedef struct packed
   {
      logic channel_on;
      logic second_input_select;
      logic differential_select;
      logic capacitive_chopping;
   } csr_cap_setup_t;

   typedef enum logic [1:0]
   {
      CSR_LS_IDLE = 2'b01,
      CSR_LS_WAIT = 2'b10
   } csr_link_state_t;

endpackage

`default_nettype wire

// ---- csr_regs_checker.sv ----
/*
 Port assertions for the status, result and setup register group.
 Assumes it is bound to csr_regs and sees only that module's ports.
*/
`timescale 1ns/1ps
`default_nettype none

module csr_regs_checker
(
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic link_clk_in,
   input wire logic link_cmd_valid_in,
   input wire csr_pkg::csr_cmd_t link_cmd_in,
   input wire logic link_busy_out,
   input wire logic [7:0] link_rdata_out,
   input wire logic link_rvalid_out,
   input wire logic cap_done_in,
   input wire logic [23:0] cap_result_in,
   input wire logic vt_done_in,
   input wire logic [23:0] vt_result_in,
   input wire logic vt_channel_on_in,
   input wire logic conv_start_in,
   input wire logic excitation_fault_in,
   input wire csr_pkg::csr_cap_setup_t cap_setup_out,
   input wire logic ready_n_out
);
   sequence s_cap_only;
      cap_done_in && cap_setup_out.channel_on && !vt_channel_on_in
      && !conv_start_in ##1 !conv_start_in;
   endsequence

   sequence s_vt_only;
      vt_done_in && vt_channel_on_in && !cap_setup_out.channel_on
      && !conv_start_in ##1 !conv_start_in;
   endsequence

   sequence s_busy_hold;
      link_busy_out[*4] ##[1:6] !link_busy_out;
   endsequence

   AST_CAP_ONLY: assert property (
      @(posedge clk_in) disable iff (!nrst_in) s_cap_only |=> !ready_n_out)
      else $error("ready pin high after capacitive result");
   AST_VT_ONLY: assert property (
      @(posedge clk_in) disable iff (!nrst_in) s_vt_only |=> !ready_n_out)
      else $error("ready pin high after volt/temp result");
   AST_START_HIGH: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      conv_start_in |-> ##[1:2] ready_n_out)
      else $error("ready pin not raised by next conversion");
   AST_BUSY_TAKE: assert property (
      @(posedge link_clk_in) disable iff (!nrst_in)
      link_cmd_valid_in && !link_busy_out |=> link_busy_out)
      else $error("command not taken");
   AST_BUSY_SPAN: assert property (
      @(posedge link_clk_in) disable iff (!nrst_in)
      $rose(link_busy_out) |-> s_busy_hold)
      else $error("busy window out of bounds");
   AST_RVALID_ONE: assert property (
      @(posedge link_clk_in) disable iff (!nrst_in)
      link_rvalid_out |=> !link_rvalid_out)
      else $error("read strobe longer than one cycle");
   AST_RVALID_END: assert property (
      @(posedge link_clk_in) disable iff (!nrst_in)
      link_rvalid_out |-> $fell(link_busy_out))
      else $error("read strobe not at end of busy");
   AST_RDATA_HOLD: assert property (
      @(posedge link_clk_in) disable iff (!nrst_in)
      !link_rvalid_out |-> $stable(link_rdata_out))
      else $error("read byte changed without strobe");
endmodule

bind csr_regs csr_regs_checker u_chk (.clk_in(clk_in), .nrst_in(nrst_in),
   .link_clk_in(link_clk_in), .link_cmd_valid_in(link_cmd_valid_in),
   .link_cmd_in(link_cmd_in), .link_busy_out(link_busy_out),
   .link_rdata_out(link_rdata_out), .link_rvalid_out(link_rvalid_out),
   .cap_done_in(cap_done_in), .cap_result_in(cap_result_in),
   .vt_done_in(vt_done_in), .vt_result_in(vt_result_in),
   .vt_channel_on_in(vt_channel_on_in), .conv_start_in(conv_start_in),
   .excitation_fault_in(excitation_fault_in),
   .cap_setup_out(cap_setup_out), .ready_n_out(ready_n_out));

`default_nettype wire

// ---- csr_link_master.sv ----
/*
 Behavioural bus master on the link: pointer, byte reads/writes, stop.
 Assumes the byte-command link of csr_regs on link_clk_in.
*/
`timescale 1ns/1ps
`default_nettype none

module csr_link_master
(
   input wire logic link_clk_in,
   input wire logic busy_in,
   input wire logic [7:0] rdata_in,
   output logic valid_out,
   output csr_pkg::csr_cmd_t cmd_out
);
   int gap = 0;

   initial
   begin
      valid_out = 1'b0;
      cmd_out = '0;
   end

   task automatic send(input csr_pkg::csr_cmd_kind_t k, input logic [7:0] d);
      int n;
      n = 0;
      repeat (gap + 1) @(posedge link_clk_in);
      valid_out <= 1'b1;
      cmd_out.kind <= k;
      cmd_out.data <= d;
      @(posedge link_clk_in);
      valid_out <= 1'b0;
      // released byte lines show the inverse, not the old byte
      cmd_out.data <= ~d;
      do @(negedge link_clk_in); while (!busy_in && ++n < 4);
      do @(negedge link_clk_in); while (busy_in && ++n < 40);
   endtask

   task automatic rd(input logic [7:0] p, input int cnt,
                     output logic [23:0] v);
      v = 24'h000000;
      send(csr_pkg::CSR_CMD_PTR, p);
      repeat (cnt)
      begin
         send(csr_pkg::CSR_CMD_RD, 8'h00);
         v = {v[15:0], rdata_in};
      end
      send(csr_pkg::CSR_CMD_STOP, 8'h00);
   endtask

   task automatic wr(input logic [7:0] p, input logic [7:0] d);
      send(csr_pkg::CSR_CMD_PTR, p);
      send(csr_pkg::CSR_CMD_WR, d & 8'he1);
      send(csr_pkg::CSR_CMD_STOP, 8'h00);
   endtask
endmodule

`default_nettype wire

// ---- tb_csr_regs.sv ----
/*
 Self-checking bench for csr_regs: link master model plus converter pulses.
 Assumes csr_pkg, csr_regs, the checker and csr_link_master are compiled.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
   begin \
      compares++; \
      if ((g) !== (e)) \
      begin \
         error_cnt++; \
         $display("Error %s exp %h got %h", nm, e, g); \
      end \
   end

module tb_csr_regs;
   logic clk = 1'b0, link_clk = 1'b0, nrst_n;
   logic cap_done = 1'b0, vt_done = 1'b0, vt_on = 1'b0;
   logic conv_start = 1'b0, exc = 1'b0, busy, rvalid, ready_n, valid;
   logic [23:0] cap_res = 24'h000000, vt_res = 24'h000000, v;
   logic [7:0] rdata, p;
   logic [7:0] su [4] = '{8'h80, 8'h40, 8'h20, 8'h01};
   csr_pkg::csr_cmd_t cmd;
   csr_pkg::csr_cap_setup_t setup;
   int error_cnt = 0, compares = 0, cycles = 0, rd_cnt = 0;

   csr_regs DUT (.clk_in(clk), .nrst_in(nrst_n), .link_clk_in(link_clk),
      .link_cmd_valid_in(valid), .link_cmd_in(cmd), .link_busy_out(busy),
      .link_rdata_out(rdata), .link_rvalid_out(rvalid),
      .cap_done_in(cap_done), .cap_result_in(cap_res), .vt_done_in(vt_done),
      .vt_result_in(vt_res), .vt_channel_on_in(vt_on),
      .conv_start_in(conv_start), .excitation_fault_in(exc),
      .cap_setup_out(setup), .ready_n_out(ready_n));
   csr_link_master m (.link_clk_in(link_clk), .busy_in(busy),
      .rdata_in(rdata), .valid_out(valid), .cmd_out(cmd));

   initial forever #12.5 clk = ~clk;
   initial
   begin
      #7;
      forever #32 link_clk = ~link_clk;
   end

   task automatic report_and_stop();
      $display("compares %0d errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         error_cnt++;
         report_and_stop();
      end
   end

   // counts read strobes on the link
   always @(posedge link_clk)
   begin
      if (rvalid === 1'b1)
      begin
         rd_cnt <= rd_cnt + 1;
      end
   end

   // one converter result pulse on channel 0 (cap) or 1 (volt/temp)
   task automatic conv(input int ch, input logic [23:0] val);
      @(posedge clk);
      cap_done <= (ch == 0);
      vt_done <= (ch != 0);
      cap_res <= val;
      vt_res <= val;
      @(posedge clk);
      cap_done <= 1'b0;
      vt_done <= 1'b0;
      repeat (4) @(posedge clk);
   endtask

   task automatic st(input logic [7:0] e);
      int n0;
      n0 = rd_cnt;
      m.rd(8'h00, 1, v);
      `CHK("status", e, v[7:0])
      `CHK("read strobes", n0 + 1, rd_cnt)
   endtask

   task automatic res(input logic [7:0] a, input logic [23:0] e);
      m.rd(a, 3, v);
      `CHK("result", e, v)
   endtask

   initial
   begin
      nrst_n <= 1'b0;
      repeat (16) @(posedge clk);
      nrst_n <= 1'b1;
      repeat (2) @(posedge clk);
      st(8'h07);
      res(8'h01, 24'h000000);
      m.rd(8'h20, 1, v);
      `CHK("unmapped", 8'h00, v[7:0])
      for (int i = 0; i < 4; i++)
      begin
         m.wr(8'h07, su[i]);
         m.rd(8'h07, 1, v);
         `CHK("setup", su[i], v[7:0])
         `CHK("setup pins", 4'h8 >> i, setup)
      end
      $display("test reset and setup finished");
      m.wr(8'h07, 8'h80);
      conv(0, 24'h800000);
      `CHK("ready pin", 1'b0, ready_n)
      st(8'h02);
      res(8'h01, 24'h800000);
      st(8'h07);
      $display("test single channel finished");
      @(posedge clk);
      vt_on <= 1'b1;
      conv(0, 24'hffffff);
      `CHK("ready pin", 1'b1, ready_n)
      st(8'h06);
      conv(1, 24'h123456);
      `CHK("ready pin", 1'b0, ready_n)
      st(8'h00);
      res(8'h04, 24'h123456);
      st(8'h06);
      res(8'h01, 24'hffffff);
      $display("test both channels finished");
      for (int ch = 0; ch < 2; ch++)
      begin
         p = (ch == 0) ? 8'h01 : 8'h04;
         m.send(csr_pkg::CSR_CMD_PTR, p);
         m.send(csr_pkg::CSR_CMD_RD, 8'h00);
         conv(ch, 24'h5a5a5a);
         m.send(csr_pkg::CSR_CMD_RD, 8'h00);
         m.send(csr_pkg::CSR_CMD_RD, 8'h00);
         m.send(csr_pkg::CSR_CMD_STOP, 8'h00);
         res(p, (ch == 0) ? 24'hffffff : 24'h123456);
         conv(ch, 24'h5a5a5a);
         res(p, 24'h5a5a5a);
      end
      $display("test update blocking finished");
      m.gap = 3;
      @(posedge clk);
      exc <= 1'b1;
      repeat (8) @(posedge clk);
      st(8'h0f);
      @(posedge clk);
      exc <= 1'b0;
      repeat (8) @(posedge clk);
      st(8'h07);
      m.gap = 0;
      $display("test excitation fault finished");
      m.wr(8'h07, 8'h00);
      conv(1, 24'hffffff);
      `CHK("ready pin", 1'b0, ready_n)
      @(posedge clk);
      conv_start <= 1'b1;
      @(posedge clk);
      conv_start <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK("ready pin", 1'b1, ready_n)
      res(8'h04, 24'hffffff);
      st(8'h07);
      conv(1, 24'h80c800);
      res(8'h04, 24'h80c800);
      `CHK("temperature", 25, int'(v) / 2048 - 4096)
      $display("test next conversion finished");
      report_and_stop();
   end
endmodule

`default_nettype wire
